/* File: logic/eeprom_pkg.sv */
// constants shared by the serial eeprom device and its host controller
// assumes a 125 MHz pclk on both ends
package eeprom_pkg;
   // ********************************
   // timing
   // ********************************
   localparam int CLK_NS = 8;
   localparam int EW_US = 5000;
   localparam int EW_CYCLES = (EW_US * 1000) / CLK_NS;
   localparam int DESELECT_NS = 250;
   localparam int DESELECT_CYC = (DESELECT_NS + CLK_NS - 1) / CLK_NS;
   localparam int LINK_HALF_CYC = 8;
   localparam int POLL_CYC = 8;
   localparam int RX_BITS = 17;
   // ********************************
   // opcodes and sub-functions
   // ********************************
   localparam logic [1:0] OP_EXT = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_ERASE = 2'h3;
   localparam logic [1:0] SUB_LOCK = 2'h0;
   localparam logic [1:0] SUB_FILL = 2'h1;
   localparam logic [1:0] SUB_CLEAR = 2'h2;
   localparam logic [1:0] SUB_UNLOCK = 2'h3;
   // ********************************
   // host register map (apb byte offsets)
   // ********************************
   localparam logic [7:0] REG_CMD = 8'h00;
   localparam logic [7:0] REG_CFG = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_RDATA = 8'h0c;
   localparam logic [7:0] REG_IRQ_STAT = 8'h10;
   localparam logic [7:0] REG_IRQ_MASK = 8'h14;
   localparam logic [1:0] IRQ_DONE = 2'h1;
   localparam logic [1:0] IRQ_REFUSED = 2'h2;
endpackage

/* File: logic/serial_link_if.sv */
// three-wire serial link plus data-out line between host and eeprom
// assumes a weak pull-down on the data-out wire
`timescale 1ns/1ps
`default_nettype none
interface serial_link_if;
   logic select;
   logic shift_clock;
   logic serial_in;
   logic serial_out;
   logic serial_out_oe;
   logic data_line;
   // floating line reads low
   assign data_line = serial_out_oe & serial_out;
   modport device (input select, input shift_clock, input serial_in, output serial_out, output serial_out_oe);
   modport host (output select, output shift_clock, output serial_in, input data_line);
endinterface
`default_nettype wire

/* File: logic/edge_sync.sv */
// two-flop synchroniser with edge detection
// assumes d is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // pin
   input wire logic d,
   // synchronised
   output logic level,
   output logic rise,
   output logic fall
);
   logic meta;
   logic prev;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= 1'b0;
         level <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= d;
         level <= meta;
         prev <= level;
      end
   end
   assign rise = level & ~prev;
   assign fall = ~level & prev;
endmodule
`default_nettype wire

/* File: logic/eeprom_device.sv */
// serial eeprom command engine with flop array, device end of serial_link_if
// assumes link pins asynchronous to pclk and sampled by edge_sync
// Function
// - frame: start bit, opcode, address, data
// - instruction nine or ten bits long
// - serial input sampled on clock rise
// - output floats except read or status
// - status low busy, high ready
// - shifted one while selected floats status
// - status off only when ready
// - read: dummy zero then word msb first
// - sequential read advances, wraps to zero
// - program ops refused unless write-enabled
// - enable persists until lock or reset; reads unaffected
// - opcodes read, erase, write decoded
// - ext opcode: unlock, lock, clear, fill
// - select fall starts self-timed write
// - write stores without clearing first
// - erase sets location to ones
// - clear-all sets whole array ones
`timescale 1ns/1ps
`default_nettype none
module eeprom_device #(
   parameter int write_cycles = eeprom_pkg::EW_CYCLES
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // strap, high selects 16-bit words
   input wire logic word_width_strap,
   // link
   serial_link_if.device link,
   // status
   output logic busy,
   output logic write_enabled
);
   // ********************************
   // types and storage
   // ********************************
   typedef enum logic [2:0] {
      D_IDLE = 3'h0,
      D_CMD = 3'h1,
      D_DATA = 3'h3,
      D_READ = 3'h2,
      D_DONE = 3'h6
   } dev_state_e;
   localparam int CW = $clog2(write_cycles + 1);
   dev_state_e state;
   logic [15:0] mem [64];
   logic [8:0] cmd_sr;
   logic [8:0] next_cmd;
   logic [15:0] din_sr;
   logic [15:0] dout_sr;
   logic [6:0] addr;
   logic [6:0] next_addr;
   logic [1:0] opc;
   logic [4:0] cnt;
   logic armed;
   logic status_en;
   logic [CW-1:0] ew_cnt;
   logic cs_s, cs_fall, lclk_rise, sin_s, strap_s, x8;
   logic start_prog;
   // ********************************
   // synchronisers
   // ********************************
   edge_sync u_cs (.clk(pclk), .rst_n(presetn), .d(link.select), .level(cs_s), .rise(), .fall(cs_fall));
   edge_sync u_lclk (.clk(pclk), .rst_n(presetn), .d(link.shift_clock), .level(), .rise(lclk_rise), .fall());
   edge_sync u_sin (.clk(pclk), .rst_n(presetn), .d(link.serial_in), .level(sin_s), .rise(), .fall());
   edge_sync u_strap (.clk(pclk), .rst_n(presetn), .d(word_width_strap), .level(strap_s), .rise(), .fall());
   assign x8 = ~strap_s;
   // ********************************
   // helpers
   // ********************************
   function automatic logic [15:0] word_at(input logic [6:0] a, input logic byte_mode);
      logic [15:0] w;
      w = mem[byte_mode ? a[6:1] : a[5:0]];
      if (byte_mode) begin
         word_at = {8'h00, a[0] ? w[15:8] : w[7:0]};
      end else begin
         word_at = w;
      end
   endfunction
   function automatic logic [1:0] sub_of(input logic [6:0] a, input logic byte_mode);
      sub_of = byte_mode ? a[6:5] : a[5:4];
   endfunction
   assign next_cmd = {cmd_sr[7:0], sin_s};
   assign next_addr = x8 ? 7'(addr + 7'h01) : {1'b0, 6'(addr[5:0] + 6'h01)};
   // ready/busy line low until the self-timed cycle ends
   assign busy = (ew_cnt != '0);
   assign start_prog = cs_fall && state == D_DONE && armed && write_enabled && !busy;
   // ********************************
   // frame decoder and serial output
   // ********************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= D_IDLE;
         cmd_sr <= 9'h000;
         din_sr <= 16'h0000;
         dout_sr <= 16'h0000;
         addr <= 7'h00;
         opc <= 2'h0;
         cnt <= 5'h00;
         armed <= 1'b0;
         write_enabled <= 1'b0;
         link.serial_out <= 1'b0;
         link.serial_out_oe <= 1'b0;
      end else if (!cs_s || cs_fall) begin
         // partial frames die here and never reach the array
         state <= D_IDLE;
         cnt <= 5'h00;
         armed <= 1'b0;
         link.serial_out_oe <= 1'b0;
      end else if (state == D_IDLE && status_en) begin
         link.serial_out_oe <= 1'b1;
         link.serial_out <= ~busy;
         if (lclk_rise && sin_s && !busy) begin
            link.serial_out_oe <= 1'b0;
            state <= D_CMD;
         end
      end else if (lclk_rise) begin
         case (state)
            D_IDLE: begin
               if (sin_s && !busy) begin
                  state <= D_CMD;
                  cnt <= 5'h00;
               end
            end
            D_CMD: begin
               cmd_sr <= next_cmd;
               cnt <= 5'(cnt + 5'h01);
               if (cnt == (x8 ? 5'h08 : 5'h07)) begin
                  opc <= x8 ? next_cmd[8:7] : next_cmd[7:6];
                  addr <= x8 ? next_cmd[6:0] : {1'b0, next_cmd[5:0]};
                  cnt <= 5'h00;
                  state <= D_DONE;
                  case (x8 ? next_cmd[8:7] : next_cmd[7:6])
                     eeprom_pkg::OP_READ: begin
                        state <= D_READ;
                        dout_sr <= word_at(x8 ? next_cmd[6:0] : {1'b0, next_cmd[5:0]}, x8);
                        link.serial_out_oe <= 1'b1;
                        link.serial_out <= 1'b0;
                     end
                     eeprom_pkg::OP_WRITE: state <= D_DATA;
                     eeprom_pkg::OP_ERASE: armed <= 1'b1;
                     default: begin
                        case (sub_of(x8 ? next_cmd[6:0] : {1'b0, next_cmd[5:0]}, x8))
                           eeprom_pkg::SUB_UNLOCK: write_enabled <= 1'b1;
                           eeprom_pkg::SUB_LOCK: write_enabled <= 1'b0;
                           eeprom_pkg::SUB_CLEAR: armed <= 1'b1;
                           default: state <= D_DATA;
                        endcase
                     end
                  endcase
               end
            end
            D_DATA: begin
               din_sr <= {din_sr[14:0], sin_s};
               cnt <= 5'(cnt + 5'h01);
               if (cnt == (x8 ? 5'h07 : 5'h0f)) begin
                  state <= D_DONE;
                  armed <= 1'b1;
               end
            end
            D_READ: begin
               link.serial_out <= x8 ? dout_sr[7] : dout_sr[15];
               dout_sr <= {dout_sr[14:0], 1'b0};
               cnt <= 5'(cnt + 5'h01);
               if (cnt == (x8 ? 5'h07 : 5'h0f)) begin
                  // no dummy bit between words
                  addr <= next_addr;
                  dout_sr <= word_at(next_addr, x8);
                  cnt <= 5'h00;
               end
            end
            D_DONE: state <= D_DONE;
            default: state <= D_IDLE;
         endcase
      end
   end
   // ********************************
   // status reporting enable
   // ********************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_en <= 1'b0;
      end else if (start_prog) begin
         status_en <= 1'b1;
      end else if (cs_s && state == D_IDLE && lclk_rise && sin_s && !busy) begin
         status_en <= 1'b0;
      end
   end
   // ********************************
   // self-timed cycle
   // ********************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ew_cnt <= '0;
      end else if (start_prog) begin
         ew_cnt <= CW'(write_cycles);
      end else if (busy) begin
         ew_cnt <= CW'(ew_cnt - 1'b1);
      end
   end
   // ********************************
   // array update, committed at cycle start
   // ********************************
   always_ff @(posedge pclk) begin
      if (start_prog) begin
         case (opc)
            eeprom_pkg::OP_WRITE: begin
               // whole value replaced, so no erase needed first
               if (!x8) begin
                  mem[addr[5:0]] <= din_sr;
               end else if (addr[0]) begin
                  mem[addr[6:1]][15:8] <= din_sr[7:0];
               end else begin
                  mem[addr[6:1]][7:0] <= din_sr[7:0];
               end
            end
            eeprom_pkg::OP_ERASE: begin
               if (!x8) begin
                  mem[addr[5:0]] <= 16'hffff;
               end else if (addr[0]) begin
                  mem[addr[6:1]][15:8] <= 8'hff;
               end else begin
                  mem[addr[6:1]][7:0] <= 8'hff;
               end
            end
            eeprom_pkg::OP_EXT: begin
               for (int i = 0; i < 64; i++) begin
                  if (sub_of(addr, x8) == eeprom_pkg::SUB_CLEAR) begin
                     mem[i] <= 16'hffff;
                  end else if (sub_of(addr, x8) == eeprom_pkg::SUB_FILL) begin
                     mem[i] <= x8 ? {din_sr[7:0], din_sr[7:0]} : din_sr;
                  end
               end
            end
            default: mem[0] <= mem[0];
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: logic/eeprom_host.sv */
// serial eeprom host controller, apb slave on the software side
// assumes apb master on pclk; drives the link clock by dividing pclk
`timescale 1ns/1ps
`default_nettype none
module eeprom_host (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // interrupt
   output logic irq,
   // link
   serial_link_if.host link
);
   // ********************************
   // state
   // ********************************
   typedef enum logic [2:0] {
      H_IDLE = 3'h0,
      H_SHIFT = 3'h1,
      H_RECV = 3'h3,
      H_DESEL = 3'h2,
      H_POLL = 3'h6
   } host_state_e;
   host_state_e state;
   logic cfg_x8;
   logic [1:0] irq_stat;
   logic [1:0] irq_mask;
   logic [15:0] rdata;
   logic [26:0] tx;
   logic [16:0] rx;
   logic [4:0] nbits;
   logic [4:0] bitcnt;
   logic [3:0] div;
   logic [5:0] wait_cnt;
   logic prog;
   logic read_frame;
   logic do_s;
   logic wr, cmd_wr, tick, done_ev, refuse_ev;
   logic [1:0] op;
   logic [6:0] a;
   logic [15:0] d;
   logic [1:0] sub;
   edge_sync u_do (.clk(pclk), .rst_n(presetn), .d(link.data_line), .level(do_s), .rise(), .fall());
   // ********************************
   // apb slave, zero wait states
   // ********************************
   assign wr = psel & penable & pwrite;
   assign cmd_wr = wr && paddr == eeprom_pkg::REG_CMD;
   assign pready = 1'b1;
   assign op = pwdata[1:0];
   assign a = pwdata[8:2];
   assign d = pwdata[31:16];
   assign sub = cfg_x8 ? a[6:5] : a[5:4];
   assign refuse_ev = cmd_wr && state != H_IDLE;
   assign irq = |(irq_stat & irq_mask);
   always_comb begin
      prdata = 32'h0000_0000;
      pslverr = 1'b0;
      case (paddr)
         eeprom_pkg::REG_CMD: prdata = 32'h0000_0000;
         eeprom_pkg::REG_CFG: prdata = {31'h0, cfg_x8};
         eeprom_pkg::REG_STATUS: prdata = {30'h0, do_s, state != H_IDLE};
         eeprom_pkg::REG_RDATA: prdata = {16'h0, rdata};
         eeprom_pkg::REG_IRQ_STAT: prdata = {30'h0, irq_stat};
         eeprom_pkg::REG_IRQ_MASK: prdata = {30'h0, irq_mask};
         default: pslverr = psel & penable;
      endcase
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_x8 <= 1'b0;
         irq_mask <= 2'h0;
         irq_stat <= 2'h0;
      end else begin
         if (wr && paddr == eeprom_pkg::REG_CFG) begin
            cfg_x8 <= pwdata[0];
         end
         if (wr && paddr == eeprom_pkg::REG_IRQ_MASK) begin
            irq_mask <= pwdata[1:0];
         end
         // a new event beats a same-cycle clear
         irq_stat <= (irq_stat & ~((wr && paddr == eeprom_pkg::REG_IRQ_STAT) ? pwdata[1:0] : 2'h0))
            | (done_ev ? eeprom_pkg::IRQ_DONE : 2'h0) | (refuse_ev ? eeprom_pkg::IRQ_REFUSED : 2'h0);
      end
   end
   // ********************************
   // link engine
   // ********************************
   assign tick = (div == 4'(eeprom_pkg::LINK_HALF_CYC - 1));
   assign done_ev = state == H_DESEL && !prog && wait_cnt == 6'(eeprom_pkg::DESELECT_CYC);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= H_IDLE;
         tx <= 27'h0;
         rx <= 17'h0;
         rdata <= 16'h0000;
         nbits <= 5'h00;
         bitcnt <= 5'h00;
         div <= 4'h0;
         wait_cnt <= 6'h00;
         prog <= 1'b0;
         link.select <= 1'b0;
         link.shift_clock <= 1'b0;
         link.serial_in <= 1'b0;
      end else begin
         div <= tick ? 4'h0 : 4'(div + 4'h1);
         case (state)
            H_IDLE: begin
               div <= 4'h0;
               wait_cnt <= 6'h00;
               if (cmd_wr) begin
                  // frame left-aligned, start bit first
                  tx <= cfg_x8 ? {1'b1, op, a, d[7:0], 9'h0} : {1'b1, op, a[5:0], d, 2'h0};
                  nbits <= (op == eeprom_pkg::OP_WRITE || (op == eeprom_pkg::OP_EXT
                     && sub == eeprom_pkg::SUB_FILL)) ? (cfg_x8 ? 5'd18 : 5'd25) : (cfg_x8 ? 5'd10 : 5'd9);
                  prog <= op != eeprom_pkg::OP_READ && !(op == eeprom_pkg::OP_EXT
                     && (sub == eeprom_pkg::SUB_LOCK || sub == eeprom_pkg::SUB_UNLOCK));
                  bitcnt <= 5'h00;
                  link.select <= 1'b1;
                  link.serial_in <= 1'b1;
                  link.shift_clock <= 1'b0;
                  state <= H_SHIFT;
               end
            end
            H_SHIFT: begin
               if (tick) begin
                  link.shift_clock <= ~link.shift_clock;
                  if (link.shift_clock) begin
                     bitcnt <= 5'(bitcnt + 5'h01);
                     tx <= {tx[25:0], 1'b0};
                     link.serial_in <= tx[25];
                     if (bitcnt == 5'(nbits - 5'h01)) begin
                        link.serial_in <= 1'b0;
                        bitcnt <= 5'h00;
                        state <= read_frame ? H_RECV : H_DESEL;
                     end
                  end
               end
            end
            H_RECV: begin
               if (tick) begin
                  link.shift_clock <= ~link.shift_clock;
                  if (!link.shift_clock) begin
                     rx <= {rx[15:0], do_s};
                     bitcnt <= 5'(bitcnt + 5'h01);
                  end else if (bitcnt == 5'(eeprom_pkg::RX_BITS)) begin
                     // byte mode keeps the addressed byte, not the one after it
                     rdata <= cfg_x8 ? {8'h00, rx[15:8]} : rx[15:0];
                     state <= H_DESEL;
                  end
               end
            end
            H_DESEL: begin
               link.select <= 1'b0;
               link.shift_clock <= 1'b0;
               wait_cnt <= 6'(wait_cnt + 6'h01);
               if (wait_cnt == 6'(eeprom_pkg::DESELECT_CYC)) begin
                  wait_cnt <= 6'h00;
                  state <= prog ? H_POLL : H_IDLE;
               end
            end
            H_POLL: begin
               link.select <= 1'b1;
               if (wait_cnt != 6'(eeprom_pkg::POLL_CYC)) begin
                  wait_cnt <= 6'(wait_cnt + 6'h01);
               end else if (do_s) begin
                  // drop select rather than shift a one: a one would start a frame
                  prog <= 1'b0;
                  wait_cnt <= 6'h00;
                  state <= H_DESEL;
               end
            end
            default: state <= H_IDLE;
         endcase
      end
   end
   // ********************************
   // read detection from the sent frame
   // ********************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         read_frame <= 1'b0;
      end else if (state == H_IDLE && cmd_wr) begin
         read_frame <= op == eeprom_pkg::OP_READ;
      end
   end
endmodule
`default_nettype wire

/* File: bench/serial_link_monitor.sv */
// checker on the serial link between host and eeprom
// assumes link signals and device busy, all in the pclk domain
`timescale 1ns/1ps
`default_nettype none
module serial_link_monitor #(
   parameter int write_cycles = 50
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // link
   input wire logic select,
   input wire logic shift_clock,
   input wire logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_oe,
   // device status
   input wire logic busy
);
   logic [5:0] low_cnt;
   logic [3:0] rise_age;
   logic [3:0] ready_age;
   logic [31:0] busy_len;
   logic prev_clk;
   logic prev_busy;
   // ****
   // helper counters; low_cnt, rise_age and ready_age saturate so they never wrap into a false pass
   // ****
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) low_cnt <= 6'h3f;
      else if (select) low_cnt <= 6'h00;
      else if (low_cnt != 6'h3f) low_cnt <= low_cnt + 6'h01;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_clk <= 1'b0;
         prev_busy <= 1'b0;
         rise_age <= 4'hf;
         ready_age <= 4'hf;
      end else begin
         prev_clk <= shift_clock;
         prev_busy <= busy;
         if (shift_clock && !prev_clk) rise_age <= 4'h0;
         else if (rise_age != 4'hf) rise_age <= rise_age + 4'h1;
         if (prev_busy && !busy) ready_age <= 4'h0;
         else if (ready_age != 4'hf) ready_age <= ready_age + 4'h1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) busy_len <= 32'h0;
      else if (busy) busy_len <= busy_len + 32'h1;
      else busy_len <= 32'h0;
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_float_deselected: assert property (!select [*4] |-> !serial_out_oe)
      else $error("data out driven while deselected");
   a_deselect_gap: assert property ($rose(select) |-> low_cnt >= 6'h20)
      else $error("deselect gap too short");
   a_clock_idle: assert property (!select [*3] |-> !shift_clock)
      else $error("link clock runs outside frame");
   a_input_steady: assert property ($changed(serial_in) && select |-> !shift_clock)
      else $error("serial input changed while clock high");
   a_out_has_cause: assert property (serial_out_oe && $past(serial_out_oe) && $changed(serial_out)
      |-> rise_age <= 4'h6 || ready_age <= 4'h6)
      else $error("data out changed without clock rise or ready");
   a_busy_drives_low: assert property (serial_out_oe && busy |-> !serial_out)
      else $error("status not low while busy");
   a_busy_after_deselect: assert property ($rose(busy) |-> !select && low_cnt >= 6'h01)
      else $error("busy started while selected");
   a_busy_length: assert property ($fell(busy) |-> busy_len >= write_cycles - 1 && busy_len <= write_cycles + 1)
      else $error("self-timed cycle length wrong");
endmodule
`default_nettype wire

/* File: bench/serial_eeprom_command_engine_bench.sv */
// bench: apb master on the host, host and eeprom joined by the link
// assumes zero-wait apb and a short self-timed cycle
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_command_engine_bench;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, word_width_strap = 1'b1;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, irq, busy, write_enabled, last_err, seen;
   int fails = 0, n_compared = 0;
   serial_link_if link();
   eeprom_device #(.write_cycles(50)) i_eeprom_device (.pclk(pclk), .presetn(presetn),
      .word_width_strap(word_width_strap), .link(link), .busy(busy), .write_enabled(write_enabled));
   eeprom_host i_eeprom_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .link(link));
   serial_link_monitor #(.write_cycles(50)) i_serial_link_monitor (.pclk(pclk), .presetn(presetn),
      .select(link.select), .shift_clock(link.shift_clock), .serial_in(link.serial_in),
      .serial_out(link.serial_out), .serial_out_oe(link.serial_out_oe), .busy(busy));
   always #4 pclk = ~pclk;
   // ****
   // tasks
   // ****
   task fail(input string s);
      fails++;
      $display("Error at %0t: %s", $time, s);
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) fail($sformatf("got %h expected %h", got, exp));
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      rd = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 100) fail("no pready");
   endtask
   // engine poll is bounded: a refused program command would never finish
   task wait_idle;
      int n;
      n = 0;
      apb(1'b0, eeprom_pkg::REG_STATUS, 32'h0);
      while (rd[0] !== 1'b0 && n < 3000) begin
         apb(1'b0, eeprom_pkg::REG_STATUS, 32'h0);
         n++;
      end
      if (n >= 3000) fail("engine stuck");
   endtask
   task cmd(input logic [1:0] op, input logic [6:0] a, input logic [15:0] d);
      apb(1'b1, eeprom_pkg::REG_CMD, {d, 7'h00, a, op});
      wait_idle();
      apb(1'b0, eeprom_pkg::REG_IRQ_STAT, 32'h0);
      chk(rd, {30'h0, eeprom_pkg::IRQ_DONE});
      apb(1'b1, eeprom_pkg::REG_IRQ_STAT, 32'h3);
   endtask
   task ext(input logic [1:0] sub, input logic [15:0] d);
      cmd(eeprom_pkg::OP_EXT, {1'b0, sub, 4'h0}, d);
   endtask
   task rdw(input logic [6:0] a, input logic [15:0] e, input logic [15:0] m);
      cmd(eeprom_pkg::OP_READ, a, 16'h0);
      apb(1'b0, eeprom_pkg::REG_RDATA, 32'h0);
      chk({16'h0, rd[15:0] & m}, {16'h0, e});
   endtask
   task conclude;
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #600000;
      fail("timeout");
      conclude();
   end
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, eeprom_pkg::REG_STATUS, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, write_enabled}, 32'h0);
      apb(1'b0, 8'h18, 32'h0);
      chk({31'h0, last_err}, 32'h1);
      $display("reset and map done");
      ext(eeprom_pkg::SUB_UNLOCK, 16'h0);
      chk({31'h0, write_enabled}, 32'h1);
      ext(eeprom_pkg::SUB_CLEAR, 16'h0);
      rdw(7'd0, 16'hffff, 16'hffff);
      rdw(7'd63, 16'hffff, 16'hffff);
      ext(eeprom_pkg::SUB_FILL, 16'h3c3c);
      rdw(7'd20, 16'h3c3c, 16'hffff);
      cmd(eeprom_pkg::OP_WRITE, 7'd5, 16'h0f0f);
      cmd(eeprom_pkg::OP_WRITE, 7'd5, 16'hf0f0);
      rdw(7'd5, 16'hf0f0, 16'hffff);
      cmd(eeprom_pkg::OP_ERASE, 7'd63, 16'h0);
      rdw(7'd63, 16'hffff, 16'hffff);
      rdw(7'd62, 16'h3c3c, 16'hffff);
      $display("program ops done");
      apb(1'b1, eeprom_pkg::REG_IRQ_MASK, 32'h3);
      apb(1'b1, eeprom_pkg::REG_CMD, {25'h0, 7'h00 | {5'h0, eeprom_pkg::OP_READ}});
      apb(1'b1, eeprom_pkg::REG_CMD, {25'h0, 7'h00 | {5'h0, eeprom_pkg::OP_READ}});
      wait_idle();
      apb(1'b0, eeprom_pkg::REG_IRQ_STAT, 32'h0);
      chk(rd, 32'h3);
      @(negedge pclk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, eeprom_pkg::REG_IRQ_STAT, 32'h1);
      apb(1'b1, eeprom_pkg::REG_IRQ_MASK, 32'h1);
      apb(1'b0, eeprom_pkg::REG_IRQ_STAT, 32'h0);
      chk(rd, 32'h2);
      @(negedge pclk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, eeprom_pkg::REG_IRQ_STAT, 32'h2);
      $display("interrupt done");
      ext(eeprom_pkg::SUB_LOCK, 16'h0);
      chk({31'h0, write_enabled}, 32'h0);
      rdw(7'd5, 16'hf0f0, 16'hffff);
      apb(1'b1, eeprom_pkg::REG_CMD, {16'h1234, 7'h00, 7'd5, eeprom_pkg::OP_WRITE});
      seen = 1'b0;
      repeat (800) begin
         @(posedge pclk);
         seen = seen | busy;
      end
      chk({31'h0, seen}, 32'h0);
      $display("lock done");
      presetn <= 1'b0;
      word_width_strap <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b1, eeprom_pkg::REG_CFG, 32'h1);
      chk({31'h0, write_enabled}, 32'h0);
      rdw(7'd11, 16'h00f0, 16'h00ff);
      rdw(7'd12, 16'h003c, 16'h00ff);
      cmd(eeprom_pkg::OP_EXT, {eeprom_pkg::SUB_UNLOCK, 5'h00}, 16'h0);
      chk({31'h0, write_enabled}, 32'h1);
      cmd(eeprom_pkg::OP_WRITE, 7'd12, 16'h005a);
      rdw(7'd12, 16'h005a, 16'hffff);
      rdw(7'd13, 16'h003c, 16'hffff);
      $display("byte mode done");
      conclude();
   end
endmodule
`default_nettype wire
